/* File: hdl/tunnel_pkg.sv */
// Shared constants, register map and carrier types of the tunnel framer
package tunnel_pkg;

	localparam logic [15:0] TUNNEL_MTU = 16'h05b4;
	localparam logic [15:0] IPV6_HDR = 16'h0028;
	localparam logic [15:0] IPV4_HDR = 16'h0014;
	localparam logic [15:0] TCP_MIN_HDR = 16'h0014;
	localparam logic [15:0] FRAG_HDR = 16'h0008;
	localparam logic [15:0] NO_LIMIT = 16'hffff;
	localparam logic [15:0] MSS_CLAMP = TUNNEL_MTU - IPV6_HDR - IPV4_HDR
		- TCP_MIN_HDR;
	localparam logic [15:0] CHUNK_A = (TUNNEL_MTU - IPV6_HDR - FRAG_HDR)
		& 16'hfff8;
	localparam logic [15:0] CHUNK_B = (TUNNEL_MTU - IPV6_HDR - IPV4_HDR)
		& 16'hfff8;
	localparam logic [7:0] ICMP_TYPE_UNREACH = 8'h03;
	localparam logic [7:0] ICMP_CODE_FRAG = 8'h04;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MAP_DHCP = 8'h04;
	localparam logic [7:0] REG_MAP_FILE = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_ADDR_BASE = 8'h10;
	localparam int ADDR_WORDS = 8;

	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_METHOD_BIT = 1;
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRL_MSS_BIT = 4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0010;
	localparam int MAP_VALID_BIT = 0;
	localparam int MAP_MESH_BIT = 1;
	localparam int MAP_PREFIX_LSB = 8;

	typedef enum logic [1:0] {MODE_ENCAP_NAT, MODE_MAP_E, MODE_MAP_T}
		tunnel_mode_t;

	typedef struct packed {
		logic [15:0] total_len;
		logic dont_frag;
		logic is_tcp;
		logic mss_present;
		logic [15:0] mss;
		logic [31:0] src_v4;
		logic [31:0] dst_v4;
	} ipv4_pkt_t;

	typedef struct packed {
		logic [127:0] src_v6;
		logic [127:0] dst_v6;
		logic translated;
		logic [15:0] payload_len;
		logic frag_hdr;
		logic [12:0] frag_off;
		logic frag_more;
		logic inner_frag;
		logic [12:0] inner_off;
		logic inner_more;
		logic mss_rewrite;
		logic [15:0] mss;
	} tunnel_frame_t;

	typedef struct packed {
		logic [7:0] icmp_type;
		logic [7:0] icmp_code;
		logic [15:0] next_hop_mtu;
		logic [31:0] dst_v4;
	} icmp_err_t;

endpackage

/* File: hdl/tunnel_framer.sv */
// Tunnel framer: frame planner, register slave and output FIFO
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps

module frame_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [CW-1:0] cnt;
	} fifo_state_t;

	fifo_state_t cur;
	fifo_state_t next_cur;
	logic push;
	logic pop;

	assign in_ready_o = (cur.cnt != CW'(DEPTH));
	assign out_valid_o = (cur.cnt != '0);
	assign out_data_o = cur.mem[cur.rd];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb
	begin
		next_cur = cur;
		if (push)
		begin
			next_cur.mem[cur.wr] = in_data_i;
			next_cur.wr = (cur.wr == AW'(DEPTH - 1)) ? '0 : cur.wr + 1'b1;
		end
		if (pop)
			next_cur.rd = (cur.rd == AW'(DEPTH - 1)) ? '0 : cur.rd + 1'b1;
		next_cur.cnt = cur.cnt + CW'(push) - CW'(pop);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cur <= '0;
		else
			cur <= next_cur;
	end
endmodule // frame_fifo

module tunnel_framer
	import tunnel_pkg::*;
#(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic pkt_valid_i,
	input wire ipv4_pkt_t pkt_i,
	output logic pkt_ready_o,
	output logic frame_valid_o,
	output tunnel_frame_t frame_o,
	input wire logic frame_ready_i,
	output logic icmp_valid_o,
	output icmp_err_t icmp_o,
	input wire logic icmp_ready_i
);
	typedef enum logic [1:0] {S_IDLE, S_EMIT, S_ICMP} fsm_t;

	typedef struct packed {
		fsm_t fsm;
		ipv4_pkt_t pkt;
		logic oversize;
		logic method_b;
		logic to_ce;
		tunnel_mode_t mode;
		logic [15:0] rem;
		logic [15:0] off;
		logic first;
		logic ack;
		logic [31:0] rdata;
		logic [31:0] ctrl;
		logic [31:0] map_dhcp;
		logic [31:0] map_file;
		logic [ADDR_WORDS-1:0][31:0] addr;
		logic [15:0] drop_cnt;
		logic [15:0] frag_cnt;
	} state_t;

	localparam int FW = $bits(tunnel_frame_t);

	state_t cur;
	state_t next_cur;
	tunnel_frame_t frm;
	logic [FW-1:0] fifo_dout;
	logic fifo_in_ready;
	logic fifo_in_valid;
	logic frame_push;
	logic wb_hit;
	logic take;
	logic take_big;
	logic [31:0] map_eff;
	logic [127:0] local_v6;
	logic [127:0] remote_v6;
	logic [15:0] limit;
	logic [15:0] chunk;
	logic last;
	logic [1:0] mode_raw;
	tunnel_mode_t mode_sel;
	logic mesh_hit;
	logic method_cfg;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				r[8*b +: 8] = wd[8*b +: 8];
		return r;
	endfunction

	assign wb_hit = wb_cyc_i && wb_stb_i && !cur.ack;
	assign wb_ack_o = cur.ack;
	assign wb_dat_o = cur.rdata;
	assign pkt_ready_o = (cur.fsm == S_IDLE);
	assign take = pkt_valid_i && pkt_ready_o && cur.ctrl[CTRL_EN_BIT];
	assign take_big = take && (pkt_i.total_len > TUNNEL_MTU);
	assign local_v6 = {cur.addr[0], cur.addr[1], cur.addr[2], cur.addr[3]};
	assign remote_v6 = {cur.addr[4], cur.addr[5], cur.addr[6], cur.addr[7]};
	assign method_cfg = cur.ctrl[CTRL_METHOD_BIT];
	assign mode_raw = cur.ctrl[CTRL_MODE_LSB +: 2];
	assign mode_sel = (mode_raw == 2'h3) ? MODE_ENCAP_NAT
		: tunnel_mode_t'(mode_raw);
	assign map_eff = cur.map_file[MAP_VALID_BIT] ? cur.map_file
		: cur.map_dhcp;
	assign mesh_hit = (mode_sel != MODE_ENCAP_NAT)
		&& map_eff[MAP_VALID_BIT] && map_eff[MAP_MESH_BIT]
		&& (map_eff[31:MAP_PREFIX_LSB]
		== pkt_i.dst_v4[31:MAP_PREFIX_LSB]);

	// Fragment size for the current frame
	assign limit = !cur.oversize ? NO_LIMIT
		: (cur.method_b ? CHUNK_B : CHUNK_A);
	assign chunk = (cur.rem > limit) ? limit : cur.rem;
	assign last = (cur.rem <= limit);
	assign fifo_in_valid = (cur.fsm == S_EMIT);
	assign frame_push = fifo_in_valid && fifo_in_ready;

	// Frame descriptor being emitted
	always_comb
	begin
		frm = '0;
		frm.src_v6 = local_v6;
		frm.dst_v6 = cur.to_ce ? {local_v6[127:64], 32'h0, cur.pkt.dst_v4}
			: remote_v6;
		frm.translated = (cur.mode == MODE_MAP_T);
		frm.frag_hdr = cur.oversize && !cur.method_b;
		frm.frag_off = cur.off[15:3];
		frm.frag_more = frm.frag_hdr && !last;
		frm.inner_frag = cur.method_b;
		frm.inner_off = cur.off[15:3];
		frm.inner_more = cur.method_b && !last;
		if (cur.method_b)
			frm.payload_len = IPV4_HDR + chunk;
		else if (cur.oversize)
			frm.payload_len = FRAG_HDR + chunk;
		else
			frm.payload_len = chunk;
		frm.mss_rewrite = cur.first && cur.ctrl[CTRL_MSS_BIT]
			&& cur.pkt.is_tcp && cur.pkt.mss_present
			&& (cur.pkt.mss > MSS_CLAMP);
		frm.mss = frm.mss_rewrite ? MSS_CLAMP : cur.pkt.mss;
	end

	// ICMP error built from the held packet
	assign icmp_valid_o = (cur.fsm == S_ICMP);
	always_comb
	begin
		icmp_o = '0;
		icmp_o.icmp_type = ICMP_TYPE_UNREACH;
		icmp_o.icmp_code = ICMP_CODE_FRAG;
		icmp_o.next_hop_mtu = TUNNEL_MTU;
		icmp_o.dst_v4 = cur.pkt.src_v4;
	end

	always_comb
	begin
		next_cur = cur;
		next_cur.ack = wb_hit;
		// Register slave
		if (wb_hit)
		begin
			next_cur.rdata = 32'h0;
			if (!wb_we_i)
			begin
				unique case (wb_adr_i)
					REG_CTRL: next_cur.rdata = cur.ctrl;
					REG_MAP_DHCP: next_cur.rdata = cur.map_dhcp;
					REG_MAP_FILE: next_cur.rdata = cur.map_file;
					REG_STATUS: next_cur.rdata = {cur.frag_cnt, cur.drop_cnt};
					default: next_cur.rdata = 32'h0;
				endcase
				for (int i = 0; i < ADDR_WORDS; i++)
					if (wb_adr_i == REG_ADDR_BASE + 8'(4 * i))
						next_cur.rdata = cur.addr[i];
			end
			else
			begin
				if (wb_adr_i == REG_CTRL)
					next_cur.ctrl = merge(cur.ctrl, wb_dat_i, wb_sel_i);
				if (wb_adr_i == REG_MAP_DHCP)
					next_cur.map_dhcp = merge(cur.map_dhcp, wb_dat_i, wb_sel_i);
				if (wb_adr_i == REG_MAP_FILE)
					next_cur.map_file = merge(cur.map_file, wb_dat_i, wb_sel_i);
				for (int i = 0; i < ADDR_WORDS; i++)
					if (wb_adr_i == REG_ADDR_BASE + 8'(4 * i))
						next_cur.addr[i] = merge(cur.addr[i], wb_dat_i, wb_sel_i);
			end
		end
		// Packet sequencer
		unique case (cur.fsm)
			S_IDLE:
			begin
				if (take)
				begin
					next_cur.pkt = pkt_i;
					next_cur.mode = mode_sel;
					next_cur.oversize = take_big;
					next_cur.to_ce = mesh_hit;
					next_cur.off = 16'h0;
					next_cur.first = 1'b1;
					if (take_big && pkt_i.dont_frag)
					begin
						next_cur.drop_cnt = cur.drop_cnt + 16'h1;
						next_cur.fsm = S_ICMP;
					end
					else
					begin
						next_cur.method_b = take_big && method_cfg
							&& (mode_sel != MODE_MAP_T);
						next_cur.rem = (next_cur.method_b
							|| mode_sel == MODE_MAP_T)
							? pkt_i.total_len - IPV4_HDR : pkt_i.total_len;
						if (take_big)
							next_cur.frag_cnt = cur.frag_cnt + 16'h1;
						next_cur.fsm = S_EMIT;
					end
				end
			end
			S_EMIT:
			begin
				if (frame_push)
				begin
					next_cur.rem = cur.rem - chunk;
					next_cur.off = cur.off + chunk;
					next_cur.first = 1'b0;
					if (last)
						next_cur.fsm = S_IDLE;
				end
			end
			S_ICMP:
			begin
				if (icmp_ready_i)
					next_cur.fsm = S_IDLE;
			end
			default: next_cur.fsm = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cur <= '0;
			cur.ctrl <= CTRL_RST;
		end
		else
			cur <= next_cur;
	end

	frame_fifo #(
		.W(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(fifo_in_valid),
		.in_data_i(FW'(frm)),
		.in_ready_o(fifo_in_ready),
		.out_valid_o(frame_valid_o),
		.out_data_o(fifo_dout),
		.out_ready_i(frame_ready_i)
	);
	assign frame_o = tunnel_frame_t'(fifo_dout);

	// Checks
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_df_take;
		take_big && pkt_i.dont_frag;
	endsequence

	sequence s_icmp_out;
		icmp_valid_o && icmp_o.icmp_type == ICMP_TYPE_UNREACH
			&& icmp_o.icmp_code == ICMP_CODE_FRAG
			&& icmp_o.next_hop_mtu == TUNNEL_MTU;
	endsequence

	chk_df_drop: assert property (s_df_take |=> !fifo_in_valid)
		else $error("DF packet was not dropped");
	chk_df_icmp: assert property (s_df_take |=> s_icmp_out)
		else $error("ICMP error missing or wrong");
	chk_drop_count: assert property (s_df_take
		|=> cur.drop_cnt == $past(cur.drop_cnt) + 16'h1)
		else $error("Drop counter not advanced");
	chk_icmp_hold: assert property (icmp_valid_o && !icmp_ready_i
		|=> icmp_valid_o && $stable(icmp_o))
		else $error("ICMP error withdrawn before taken");
	chk_big_frag: assert property (take_big && !pkt_i.dont_frag
		|=> fifo_in_valid && (frm.frag_hdr || frm.inner_frag))
		else $error("Oversize packet not fragmented");
	chk_frag_fit: assert property (frame_push
		&& (frm.frag_hdr || frm.inner_frag)
		|-> frm.payload_len + IPV6_HDR <= TUNNEL_MTU)
		else $error("Fragment exceeds tunnel MTU");
	chk_method_a: assert property (frame_push && cur.oversize
		&& !cur.method_b |-> frm.frag_hdr && !frm.inner_frag)
		else $error("Method one frame malformed");
	chk_method_b: assert property (frame_push && cur.method_b
		|-> frm.inner_frag && !frm.frag_hdr)
		else $error("Method two frame malformed");
	chk_method_sel: assert property (take_big && !pkt_i.dont_frag
		&& mode_sel != MODE_MAP_T |=> cur.method_b == $past(method_cfg))
		else $error("Fragment method not as configured");
	chk_mss_clamp: assert property (frame_push && cur.first
		&& cur.ctrl[CTRL_MSS_BIT] && cur.pkt.is_tcp
		&& cur.pkt.mss_present && cur.pkt.mss > MSS_CLAMP
		|-> frm.mss_rewrite && frm.mss == MSS_CLAMP)
		else $error("MSS clamp value wrong");
	chk_translate: assert property (frame_push
		|-> frm.translated == (cur.mode == MODE_MAP_T))
		else $error("Translation flag wrong");
	chk_mode_fold: assert property (take && mode_raw == 2'h3
		|=> cur.mode == MODE_ENCAP_NAT)
		else $error("Reserved mode not folded to encapsulation");
	chk_cfg_pref: assert property (take && cur.map_file[MAP_VALID_BIT]
		&& cur.map_file[MAP_MESH_BIT] == 1'b0 |=> !cur.to_ce)
		else $error("DHCP mapping used over file mapping");
	chk_mesh_take: assert property (take && !pkt_i.dont_frag
		&& mesh_hit |=> cur.to_ce)
		else $error("Mesh rule not applied");
	chk_relay_dst: assert property (frame_push && !cur.to_ce
		|-> frm.dst_v6 == remote_v6 && frm.src_v6 == local_v6)
		else $error("Tunnel addresses wrong");
	chk_wb_ack: assert property (wb_hit |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Bus ack timing wrong");
endmodule // tunnel_framer

/* File: tb/op_net_sink.sv */
// Operator network sink model for tunnel frames and ICMP errors
`timescale 1ns/100ps
module op_net_sink (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic stall_i,
	input wire logic frame_valid_i,
	input wire logic icmp_valid_i,
	output logic frame_ready_o,
	output logic icmp_ready_o
);
	// Slow link: takes a frame every other cycle unless stalled
	logic tick;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tick <= 1'b0;
		else
			tick <= ~tick;
	end
	assign frame_ready_o = ~stall_i & tick & frame_valid_i;
	assign icmp_ready_o = ~stall_i & icmp_valid_i;
endmodule // op_net_sink

/* File: tb/ipv4_in_ipv6_tunnel_fragmenter_bench.sv */
// Self-checking bench for the tunnel framer
`timescale 1ns/100ps
module ipv4_in_ipv6_tunnel_fragmenter_bench;
	import tunnel_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic ack;
	logic pv = 1'b0;
	ipv4_pkt_t pkt = '0;
	logic rdy;
	logic fv;
	tunnel_frame_t fo;
	logic f_rdy;
	logic iv;
	icmp_err_t io;
	logic i_rdy;
	logic stall = 1'b0;
	int miscompares = 0;
	int n_tests = 0;
	tunnel_frame_t fq[$];
	icmp_err_t iq[$];
	logic [127:0] loc;
	logic [127:0] nat;
	always #12.5 clk_i = ~clk_i;
	tunnel_framer #(.FIFO_DEPTH(4)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.pkt_valid_i(pv), .pkt_i(pkt), .pkt_ready_o(rdy),
		.frame_valid_o(fv), .frame_o(fo), .frame_ready_i(f_rdy),
		.icmp_valid_o(iv), .icmp_o(io), .icmp_ready_i(i_rdy));
	op_net_sink sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
		.frame_valid_i(fv), .icmp_valid_i(iv), .frame_ready_o(f_rdy),
		.icmp_ready_o(i_rdy));
	always @(negedge clk_i)
	begin
		if (fv === 1'b1 && f_rdy === 1'b1)
			fq.push_back(fo);
		if (iv === 1'b1 && i_rdy === 1'b1)
			iq.push_back(io);
	end
	task automatic give_verdict();
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [127:0] e, g);
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
			@(posedge clk_i);
		while (ack !== 1'b1 && n++ < 50);
		chk("wb_ack", 1, ack);
		q = rdat;
		cyc <= 1'b0;
	endtask
	task automatic send(input logic [15:0] len, input logic df, tcp,
		input logic [31:0] dst);
		int n;
		n = 0;
		@(posedge clk_i);
		pv <= 1'b1;
		pkt <= '{len, df, tcp, tcp, 16'h05b4, 32'hc0a8_0001, dst};
		do
			@(posedge clk_i);
		while (rdy !== 1'b1 && n++ < 400);
		chk("pkt_ready", 1, rdy);
		pv <= 1'b0;
	endtask
	task automatic wait_q(input int n);
		int k;
		k = 0;
		while (fq.size() < n && k++ < 300)
			@(negedge clk_i);
		chk("frames", n, fq.size());
	endtask
	task automatic fr(input logic [15:0] len, input logic fh, more,
		input logic [12:0] off);
		tunnel_frame_t f;
		f = fq.pop_front();
		chk("payload_len", len, f.payload_len);
		chk("frag_hdr", fh, f.frag_hdr);
		chk("more", more, fh ? f.frag_more : f.inner_more);
		chk("offset", off, fh ? f.frag_off : f.inner_off);
	endtask
	task automatic t_reset();
		wb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl_reset", 32'h0000_0010, q);
		wb(1'b0, 8'hfc, 32'h0);
		chk("unmapped", 32'h0, q);
		send(16'd100, 1'b0, 1'b0, 32'h0808_0808);
		repeat (20) @(negedge clk_i);
		chk("off_frames", 0, fq.size());
		for (int k = 0; k < 4; k++)
		begin
			wb(1'b1, REG_ADDR_BASE + 8'(4 * k), 32'h1000_0000 + k);
			wb(1'b1, REG_ADDR_BASE + 8'(16 + 4 * k), 32'h2000_0000 + k);
			loc[127 - 32 * k -: 32] = 32'h1000_0000 + k;
			nat[127 - 32 * k -: 32] = 32'h2000_0000 + k;
		end
		wb(1'b1, REG_CTRL, 32'h0000_0011);
	endtask
	task automatic t_size();
		send(16'd1460, 1'b1, 1'b0, 32'h0808_0808);
		wait_q(1);
		chk("src_v6", loc, fq[0].src_v6);
		chk("dst_v6", nat, fq[0].dst_v6);
		fr(16'd1460, 1'b0, 1'b0, 13'h0);
		send(16'd1461, 1'b1, 1'b0, 32'h0808_0808);
		repeat (20) @(negedge clk_i);
		chk("df_frames", 0, fq.size());
		chk("icmp_n", 1, iq.size());
		chk("icmp_type", 8'h03, iq[0].icmp_type);
		chk("icmp_code", 8'h04, iq[0].icmp_code);
		chk("icmp_mtu", 16'h05b4, iq[0].next_hop_mtu);
		chk("icmp_dst", 32'hc0a8_0001, iq[0].dst_v4);
	endtask
	task automatic t_method_one();
		int rem;
		@(posedge clk_i);
		stall <= 1'b1;
		send(16'd5000, 1'b0, 1'b0, 32'h0808_0808);
		send(16'd100, 1'b0, 1'b0, 32'h0808_0808);
		repeat (10) @(negedge clk_i);
		chk("full_busy", 0, rdy);
		chk("full_valid", 1, fv);
		@(posedge clk_i);
		stall <= 1'b0;
		wait_q(5);
		for (int k = 0; k < 4; k++)
		begin
			rem = 5000 - k * CHUNK_A;
			fr(16'(rem > CHUNK_A ? CHUNK_A + FRAG_HDR : rem + FRAG_HDR),
				1'b1, rem > CHUNK_A, 13'(k * CHUNK_A / 8));
		end
		fr(16'd100, 1'b0, 1'b0, 13'h0);
	endtask
	task automatic t_method_two();
		int rem;
		wb(1'b1, REG_CTRL, 32'h0000_0013);
		send(16'd3000, 1'b0, 1'b0, 32'h0808_0808);
		wait_q(3);
		for (int k = 0; k < 3; k++)
		begin
			rem = 2980 - k * CHUNK_B;
			fr(16'(rem > CHUNK_B ? CHUNK_B + 20 : rem + 20),
				1'b0, rem > CHUNK_B, 13'(k * CHUNK_B / 8));
		end
	endtask
	task automatic t_mss();
		wb(1'b1, REG_CTRL, 32'h0000_0011);
		send(16'd100, 1'b0, 1'b1, 32'h0808_0808);
		wait_q(1);
		chk("mss_rw", 1, fq[0].mss_rewrite);
		chk("mss", 16'h0564, fq[0].mss);
		void'(fq.pop_front());
		wb(1'b1, REG_CTRL, 32'h0000_0001);
		send(16'd100, 1'b0, 1'b1, 32'h0808_0808);
		wait_q(1);
		chk("mss_off_rw", 0, fq[0].mss_rewrite);
		chk("mss_off", 16'h05b4, fq[0].mss);
		void'(fq.pop_front());
	endtask
	task automatic t_map();
		tunnel_frame_t f;
		wb(1'b1, REG_CTRL, 32'h0000_0015);
		wb(1'b1, REG_MAP_DHCP, 32'h0a0b_0c03);
		wb(1'b1, REG_MAP_FILE, 32'h0a0b_0c01);
		send(16'd100, 1'b0, 1'b0, 32'h0a0b_0c05);
		wait_q(1);
		chk("relay_dst", nat, fq[0].dst_v6);
		chk("map_e", 0, fq[0].translated);
		void'(fq.pop_front());
		wb(1'b1, REG_MAP_FILE, 32'h0a0b_0c03);
		send(16'd100, 1'b0, 1'b0, 32'h0a0b_0c05);
		wait_q(1);
		f = fq.pop_front();
		chk("mesh_dst", {loc[127:64], 32'h0, 32'h0a0b_0c05},
			f.dst_v6);
		wb(1'b1, REG_MAP_FILE, 32'h0000_0000);
		send(16'd100, 1'b0, 1'b0, 32'h0a0b_0c07);
		wait_q(1);
		f = fq.pop_front();
		chk("dhcp_mesh", {loc[127:64], 32'h0, 32'h0a0b_0c07},
			f.dst_v6);
		wb(1'b1, REG_CTRL, 32'h0000_0019);
		send(16'd100, 1'b0, 1'b0, 32'h0808_0808);
		wait_q(1);
		chk("map_t", 1, fq[0].translated);
		fr(16'd80, 1'b0, 1'b0, 13'h0);
		wb(1'b1, REG_CTRL, 32'h0000_001d);
		send(16'd100, 1'b0, 1'b0, 32'h0a0b_0c05);
		wait_q(1);
		chk("mode3_dst", nat, fq[0].dst_v6);
		chk("mode3_enc", 0, fq[0].translated);
		fr(16'd100, 1'b0, 1'b0, 13'h0);
	endtask
	task automatic t_rerun();
		wb(1'b0, REG_STATUS, 32'h0);
		chk("status", 32'h0002_0001, q);
		wb(1'b0, REG_ADDR_BASE, 32'h0);
		chk("addr_rb", 32'h1000_0000, q);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl_rerun", 32'h0000_0010, q);
		wb(1'b0, REG_STATUS, 32'h0);
		chk("status_rerun", 32'h0, q);
	endtask
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_size();
		t_method_one();
		t_method_two();
		t_mss();
		t_map();
		t_rerun();
		give_verdict();
	end
	initial
	begin
		#500000;
		miscompares++;
		give_verdict();
	end
endmodule // ipv4_in_ipv6_tunnel_fragmenter_bench
